// ---- nfhc_ctrl.sv ----
// Host controller that drives a byte-wide NAND flash through its pins
`timescale 1ns/100ps
`default_nettype none
module nfhc_ctrl (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // User request side
  input wire logic REQ_VALID,
  input wire nfhc_pkg::nfhc_req_t REQ,
  output logic REQ_READY,
  output logic RESP_VALID,
  output var nfhc_pkg::nfhc_resp_t RESP,
  // Flash strobes
  output logic CE_N,
  output logic CLE,
  output logic ALE,
  output logic WE_N,
  output logic READ_STROBE_N,
  output logic WP_N,
  // Flash data port and busy line
  output logic [7:0] IO_OUT,
  output logic IO_OE_N,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY
);
  import nfhc_pkg::*;

  typedef enum {S_PWRUP, S_IDLE, S_FETCH, S_WE_LO, S_WE_HI, S_WAIT_WB, S_WAIT_RB, S_RE_LO, S_RE_HI, S_DONE} nfhc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Operation scripts: one step per index
  function automatic nfhc_step_t step_of(nfhc_op_t op, logic [3:0] i, logic [15:0] s, logic [15:0] d);
    nfhc_step_t st;
    st = '{K_END, 8'h00};
    unique case (op)
      OP_READ, OP_COPYBACK: begin
        case (i)
          4'd0: st = '{K_CMD, CMD_READ1};
          4'd1: st = '{K_ADDR, COL_ADDR};
          4'd2: st = '{K_ADDR, s[7:0]};
          4'd3: st = '{K_ADDR, s[15:8]};
          // no burst, only wait for ready
          4'd4: st = '{K_WAIT, 8'h00};
          // no page program op, so copied pages never get partial programs
          4'd5: st = (op == OP_COPYBACK) ? nfhc_step_t'{K_CMD, CMD_COPYBACK} : nfhc_step_t'{K_END, 8'h00};
          4'd6: st = '{K_ADDR, COL_ADDR};
          4'd7: st = '{K_ADDR, d[7:0]};
          4'd8: st = '{K_ADDR, d[15:8]};
          4'd9: st = '{K_WAIT, 8'h00};
          4'd10: st = '{K_CMD, CMD_STATUS};
          4'd11: st = '{K_READ, 8'h00};
          default: st = '{K_END, 8'h00};
        endcase
      end
      OP_ERASE: begin
        case (i)
          // setup and two block address cycles
          4'd0: st = '{K_CMD, CMD_ERASE_SETUP};
          // page bits below the plane bit sent as zero
          4'd1: st = '{K_ADDR, s[7:0] & ERASE_ROW_MASK};
          4'd2: st = '{K_ADDR, s[15:8]};
          4'd3: st = '{K_CMD, CMD_ERASE_GO};
          4'd4: st = '{K_WAIT, 8'h00};
          4'd5: st = '{K_CMD, CMD_STATUS};
          4'd6: st = '{K_READ, 8'h00};
          default: st = '{K_END, 8'h00};
        endcase
      end
      OP_STATUS: begin
        case (i)
          4'd0: st = '{K_CMD, CMD_STATUS};
          4'd1: st = '{K_READ, 8'h00};
          default: st = '{K_END, 8'h00};
        endcase
      end
      OP_READ_ID: begin
        // id command, address 00h, two reads
        case (i)
          4'd0: st = '{K_CMD, CMD_READ_ID};
          4'd1: st = '{K_ADDR, ID_ADDR};
          4'd2: st = '{K_READ, 8'h00};
          4'd3: st = '{K_READ, 8'h00};
          default: st = '{K_END, 8'h00};
        endcase
      end
      OP_RESET: begin
        // reset command then wait out the busy time
        case (i)
          4'd0: st = '{K_CMD, CMD_RESET};
          4'd1: st = '{K_WAIT, 8'h00};
          default: st = '{K_END, 8'h00};
        endcase
      end
      default: st = '{K_END, 8'h00};
    endcase
    return st;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  nfhc_state_t state_ff, nxt_state;
  nfhc_req_t req_ff, nxt_req;
  nfhc_step_t step_ff, nxt_step;
  logic [3:0] idx_ff, nxt_idx;
  logic [7:0] cnt_ff, nxt_cnt;
  logic rd_idx_ff, nxt_rd_idx;
  logic [7:0] rdbuf_ff [2];
  logic refused_ff, nxt_refused;
  logic reset_state_ff, nxt_reset_state;
  logic [7:0] io_s1_ff, io_s2_ff;
  logic rb_s1_ff, rb_s2_ff;

  // Decoding wires
  wire plane_bad = (REQ.op == OP_COPYBACK) && (REQ.src_row[PLANE_ROW_BIT] != REQ.dst_row[PLANE_ROW_BIT]);
  wire reset_dup = (REQ.op == OP_RESET) && reset_state_ff;
  wire take = (state_ff == S_IDLE) && REQ_VALID;
  wire nfhc_step_t cur_step = step_of(req_ff.op, idx_ff, req_ff.src_row, req_ff.dst_row);
  wire [7:0] lim = (state_ff == S_PWRUP) ? POWERUP_CYC :
                   (state_ff == S_WE_LO) ? WP_CYC :
                   (state_ff == S_WE_HI) ? WH_CYC :
                   (state_ff == S_WAIT_WB) ? WB_CYC :
                   (state_ff == S_RE_LO) ? REA_CYC : REH_CYC;
  wire cnt_done = (cnt_ff == lim - 8'h01);
  wire sample = (state_ff == S_RE_LO) && cnt_done;
  wire has_fail = (req_ff.op == OP_COPYBACK) || (req_ff.op == OP_ERASE) || (req_ff.op == OP_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_step = step_ff;
    nxt_idx = idx_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_refused = refused_ff;
    nxt_reset_state = reset_state_ff;
    unique case (state_ff)
      S_PWRUP: if (cnt_done) nxt_state = S_IDLE;
      S_IDLE: begin
        if (take) begin
          nxt_req = REQ;
          nxt_idx = 4'd0;
          nxt_rd_idx = 1'b0;
          // cross-plane copy-back refused; repeated reset skipped
          nxt_refused = plane_bad;
          nxt_state = (plane_bad || reset_dup) ? S_DONE : S_FETCH;
          // A refused request never reaches the device, so its reset state stays
          nxt_reset_state = plane_bad ? reset_state_ff : (REQ.op == OP_RESET);
        end
      end
      S_FETCH: begin
        nxt_step = cur_step;
        unique case (cur_step.kind)
          K_CMD, K_ADDR: nxt_state = S_WE_LO;
          K_WAIT: nxt_state = S_WAIT_WB;
          K_READ: nxt_state = S_RE_LO;
          default: nxt_state = S_DONE;
        endcase
      end
      S_WE_LO: if (cnt_done) nxt_state = S_WE_HI;
      S_WE_HI: begin
        if (cnt_done) begin
          nxt_idx = idx_ff + 4'd1;
          nxt_state = S_FETCH;
        end
      end
      S_WAIT_WB: if (cnt_done) nxt_state = S_WAIT_RB;
      // nothing written while the device is busy
      S_WAIT_RB: begin
        if (rb_s2_ff) begin
          nxt_idx = idx_ff + 4'd1;
          nxt_state = S_FETCH;
        end
      end
      S_RE_LO: if (cnt_done) nxt_state = S_RE_HI;
      S_RE_HI: begin
        if (cnt_done) begin
          nxt_idx = idx_ff + 4'd1;
          nxt_rd_idx = 1'b1;
          nxt_state = S_FETCH;
        end
      end
      S_DONE: nxt_state = S_IDLE;
    endcase
    nxt_cnt = (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
  end

  // Pin levels for the coming cycle
  wire nxt_we_lo = (nxt_state == S_WE_LO);
  wire nxt_drive = (nxt_state == S_WE_LO) || (nxt_state == S_WE_HI);
  wire nxt_active = (nxt_state != S_IDLE) && (nxt_state != S_PWRUP);
  wire nxt_is_cmd = nxt_drive && (nxt_step.kind == K_CMD);
  wire nxt_is_addr = nxt_drive && (nxt_step.kind == K_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge REF_CLK) begin
    io_s1_ff <= IO_IN;
    io_s2_ff <= io_s1_ff;
    rb_s1_ff <= READY_BUSY;
    rb_s2_ff <= rb_s1_ff;
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      state_ff <= S_PWRUP;
      req_ff <= '0;
      step_ff <= '{K_END, 8'h00};
      idx_ff <= 4'd0;
      cnt_ff <= 8'h00;
      rd_idx_ff <= 1'b0;
      refused_ff <= 1'b0;
      reset_state_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      step_ff <= nxt_step;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      rd_idx_ff <= nxt_rd_idx;
      refused_ff <= nxt_refused;
      reset_state_ff <= nxt_reset_state;
    end
  end

  // Read capture: status byte or id bytes
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      rdbuf_ff[0] <= STATUS_RESET;
      rdbuf_ff[1] <= 8'h00;
    end else if (sample) begin
      rdbuf_ff[rd_idx_ff] <= io_s2_ff;
    end
  end

  // strobes and latch enables from flops
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      CE_N <= 1'b1;
      CLE <= 1'b0;
      ALE <= 1'b0;
      WE_N <= 1'b1;
      READ_STROBE_N <= 1'b1;
      WP_N <= 1'b0;
      IO_OUT <= 8'h00;
      IO_OE_N <= 1'b1;
      REQ_READY <= 1'b0;
    end else begin
      CE_N <= !nxt_active;
      CLE <= nxt_is_cmd;
      ALE <= nxt_is_addr;
      WE_N <= !nxt_we_lo;
      READ_STROBE_N <= (nxt_state != S_RE_LO);
      WP_N <= (nxt_state != S_PWRUP);
      IO_OUT <= nxt_drive ? nxt_step.data : 8'h00;
      IO_OE_N <= !nxt_drive;
      REQ_READY <= (nxt_state == S_IDLE);
    end
  end

  // Response on completion
  // copied data unchecked here
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      RESP_VALID <= 1'b0;
      RESP <= '0;
    end else begin
      RESP_VALID <= (state_ff == S_DONE);
      if (state_ff == S_DONE) begin
        RESP.status <= rdbuf_ff[0];
        RESP.id_maker <= rdbuf_ff[0];
        RESP.id_device <= rdbuf_ff[1];
        // pass/fail bit forwarded as the failure flag for copy-back, erase and status only, and never for a refused request
        RESP.fail <= has_fail && !refused_ff && rdbuf_ff[0][ST_FAIL_BIT];
        RESP.refused <= refused_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_latch_excl: assert property (@(posedge REF_CLK) disable iff (!RESETN) !(CLE && ALE))
    else $error("Command and address latch both high");
  a_latch_drive: assert property (@(posedge REF_CLK) disable iff (!RESETN) (!WE_N && (CLE || ALE)) |-> (!IO_OE_N && !CE_N))
    else $error("Latch cycle without data drive");
  a_erase_mask: assert property (@(posedge REF_CLK) disable iff (!RESETN) (ALE && !WE_N && req_ff.op == OP_ERASE && idx_ff == 4'd1) |-> (IO_OUT[4:0] == 5'h00))
    else $error("Erase address carries page bits");
  a_plane_refuse: assert property (@(posedge REF_CLK) disable iff (!RESETN) (take && plane_bad) |=> (state_ff == S_DONE) ##1 (RESP_VALID && RESP.refused && CE_N))
    else $error("Cross-plane copy-back not refused");
  a_pwrup_quiet: assert property (@(posedge REF_CLK) disable iff (!RESETN) (state_ff == S_PWRUP) |-> (!WP_N && WE_N && CE_N && !CLE))
    else $error("Activity during power-up recovery");
  a_busy_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN) (state_ff == S_WAIT_RB && !rb_s2_ff) |=> (WE_N && READ_STROBE_N))
    else $error("Strobe while device busy");
  a_fail_report: assert property (@(posedge REF_CLK) disable iff (!RESETN) (RESP_VALID && !RESP.refused && (req_ff.op == OP_ERASE || req_ff.op == OP_COPYBACK)) |-> (RESP.fail == RESP.status[ST_FAIL_BIT] && RESP.status[ST_READY_BIT]))
    else $error("Failure flag differs from status bit");
  a_strobe_excl: assert property (@(posedge REF_CLK) disable iff (!RESETN) !(!WE_N && !READ_STROBE_N))
    else $error("Write and read strobes both low");
  a_erase_start: assert property (@(posedge REF_CLK) disable iff (!RESETN) ($rose(WE_N) && CLE && IO_OUT == CMD_ERASE_GO) |-> ##[1:8] (state_ff == S_WAIT_WB))
    else $error("Erase confirm not followed by busy wait");
endmodule
`default_nettype wire

// ---- nfhc_pkg.sv ----
// Constants, commands and carrier types of the NAND flash host controller
package nfhc_pkg;
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_POWERUP_NS = 1000;
  localparam int T_WB_NS = 100;
  localparam int T_WP_NS = 25;
  localparam int T_WH_NS = 15;
  localparam int T_REA_NS = 35;
  localparam int T_REH_NS = 15;
  localparam int SYNC_CYC = 2;
  // Least times round up to whole cycles, never below one
  localparam logic [7:0] POWERUP_CYC = 8'((T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WH_CYC = 8'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REA_CYC = 8'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);
  localparam logic [7:0] REH_CYC = 8'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Command bytes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_COPYBACK = 8'h8A;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR = 8'h00;
  localparam logic [7:0] COL_ADDR = 8'h00;
  // Result flag fields of the device
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_WP_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  // Row address: bit 0 is A9, so the plane bit sits at row bit 5
  localparam int PLANE_ROW_BIT = 5;
  localparam logic [7:0] ERASE_ROW_MASK = 8'hE0;
  // Requests and script steps
  typedef enum logic [2:0] {OP_READ, OP_COPYBACK, OP_ERASE, OP_STATUS, OP_READ_ID, OP_RESET} nfhc_op_t;
  typedef enum logic [2:0] {K_CMD, K_ADDR, K_WAIT, K_READ, K_END} nfhc_kind_t;
  typedef struct packed {
    nfhc_kind_t kind;
    logic [7:0] data;
  } nfhc_step_t;
  typedef struct packed {
    nfhc_op_t op;
    logic [15:0] src_row;
    logic [15:0] dst_row;
  } nfhc_req_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] id_maker;
    logic [7:0] id_device;
    logic fail;
    logic refused;
  } nfhc_resp_t;
endpackage

// ---- nfhc_flash_model.sv ----
// Behavioural NAND flash device that faces the host controller
`timescale 1ns/100ps
`default_nettype none
module nfhc_flash_model #(
  parameter int BUSY_TICKS = 16,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'hA5 // Arbitrary value
) (
  // Strobes from the host
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  // Data port, fault injection and busy
  input wire logic [7:0] dq_in,
  input wire logic fail_inj,
  output logic [7:0] dq_out,
  output logic rb_low
);
  localparam int M_READ = 0, M_STATUS = 1, M_ID = 2, M_IDLE = 3;
  logic [8:0] log_q[$];
  int busy_left = 0;
  int mode = M_READ;
  int naddr = 0;
  int rd_idx = 0;
  logic [7:0] pend = 8'hFF;
  logic fail_st = 1'b0;
  logic in_reset = 1'b0;
  logic buf_ok = 1'b0;
  logic [10:0] blk = 11'h000;
  logic [7:0] last_val = 8'h00;
  logic ready;
  logic drive;
  logic [7:0] status;
  logic [7:0] val;
  ////////////////////////////////////////////////////////////
  // live status byte
  assign ready = (busy_left == 0);
  assign status = {wp_n, ready, 5'h00, fail_st};
  assign val = (mode == M_STATUS) ? status : ((rd_idx == 0) ? MAKER_CODE : DEVICE_CODE);
  assign drive = !ce_n && !re_n && (mode == M_STATUS || mode == M_ID);
  // Released bus shows the inverse of the last byte
  assign dq_out = drive ? val : ~last_val;
  assign rb_low = !ready;
  // Internal operation timer, free of the host clock
  always #37 begin
    if (busy_left > 0) busy_left--;
  end
  always @(posedge re_n) begin
    last_val = val;
    if (!ce_n && mode == M_ID) rd_idx++;
  end
  task automatic take_cmd(input logic [7:0] c);
    if (c == 8'hFF && !in_reset) begin
      busy_left = BUSY_TICKS;
      fail_st = 1'b0;
      mode = M_IDLE;
      pend = c;
    end
    if (c == 8'hFF) in_reset = 1'b1;
    if (c == 8'hFF || (!ready && c != 8'h70)) return;
    in_reset = 1'b0;
    if (c == 8'h70) mode = M_STATUS;
    else if (c == 8'hD0 && pend == 8'h60 && naddr == 2) begin
      busy_left = BUSY_TICKS;
      fail_st = fail_inj;
      pend = c;
    end else begin
      pend = c;
      naddr = 0;
      rd_idx = 0;
      if (c == 8'h90) mode = M_ID;
      else if (c == 8'h00) mode = M_READ;
    end
  endtask
  task automatic take_addr(input logic [7:0] a);
    naddr++;
    if (pend == 8'h60 && naddr == 1) blk[2:0] = a[7:5];
    if (pend == 8'h60 && naddr == 2) blk[10:3] = a;
    if (pend == 8'h00 && naddr == 3) begin
      busy_left = BUSY_TICKS;
      buf_ok = 1'b1;
    end
    if (pend == 8'h8A && naddr == 3 && buf_ok) begin
      busy_left = BUSY_TICKS;
      fail_st = fail_inj;
    end
  endtask
  always @(posedge we_n) begin
    if (!ce_n && (cle ^ ale)) begin
      log_q.push_back({cle, dq_in});
      if (cle) take_cmd(dq_in);
      else if (ready) take_addr(dq_in);
    end
  end
endmodule
`default_nettype wire

// ---- tb_nand_flash_cmd_status_erase_copyback.sv ----
// Self-checking bench for the NAND flash host controller
`timescale 1ns/100ps
`default_nettype none
module tb_nand_flash_cmd_status_erase_copyback;
  import nfhc_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'hA5; // Arbitrary value
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  nfhc_req_t req = '0;
  logic fail_inj = 1'b0;
  logic req_ready, resp_valid, ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb_low;
  nfhc_resp_t resp;
  logic [7:0] io_out, dq_out;
  wire [7:0] io_in;
  wire ready_busy;
  int err_count = 0;
  int checks = 0;
  logic ref_fail = 1'b0;
  logic ref_rst = 1'b0;
  logic [8:0] exp_q[$];
  ////////////////////////////////////////////////////////////
  // Clock, shared data bus and pulled-up busy line
  always #25 ref_clk = ~ref_clk;
  assign io_in = (io_oe_n === 1'b0) ? io_out : dq_out;
  assign ready_busy = ~rb_low;
  nfhc_ctrl dut_u (.REF_CLK(ref_clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .RESP_VALID(resp_valid), .RESP(resp), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n), .READ_STROBE_N(re_n),
    .WP_N(wp_n), .IO_OUT(io_out), .IO_OE_N(io_oe_n), .IO_IN(io_in), .READY_BUSY(ready_busy));
  nfhc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash_u (.ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .dq_in(io_out), .fail_inj(fail_inj), .dq_out(dq_out), .rb_low(rb_low));
  // Reporting and comparison
  task automatic miss(input string m);
    err_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) miss($sformatf("%s got %h want %h", m, g, e));
  endtask
  task automatic cmp1(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) miss($sformatf("%s got %b want %b", m, g, e));
  endtask
  task automatic cmp_log();
    checks++;
    if (flash_u.log_q.size() != exp_q.size()) begin
      miss($sformatf("pin cycles %0d want %0d", flash_u.log_q.size(), exp_q.size()));
    end else begin
      foreach (exp_q[i]) begin
        if (flash_u.log_q[i] !== exp_q[i]) miss($sformatf("pin cycle %0d got %h want %h", i, flash_u.log_q[i], exp_q[i]));
      end
    end
  endtask
  // Expected pin sequence
  task automatic push(input logic c, input logic [7:0] b);
    exp_q.push_back({c, b});
  endtask
  task automatic push_row(input logic [7:0] c, input logic [15:0] r);
    push(1'b1, c);
    push(1'b0, COL_ADDR);
    push(1'b0, r[7:0]);
    push(1'b0, r[15:8]);
  endtask
  // One request with reference model and checks
  task automatic run_op(input nfhc_op_t op, input logic [15:0] s, input logic [15:0] d, input logic inj);
    logic refuse;
    logic prog;
    int n;
    refuse = (op == OP_COPYBACK) && (s[PLANE_ROW_BIT] !== d[PLANE_ROW_BIT]);
    prog = (op == OP_ERASE) || (op == OP_COPYBACK && !refuse);
    exp_q.delete();
    flash_u.log_q.delete();
    if (op == OP_READ || (op == OP_COPYBACK && !refuse)) push_row(CMD_READ1, s);
    if (op == OP_COPYBACK && !refuse) push_row(CMD_COPYBACK, d);
    if (op == OP_ERASE) begin
      push(1'b1, CMD_ERASE_SETUP);
      push(1'b0, s[7:0] & ERASE_ROW_MASK);
      push(1'b0, s[15:8]);
      push(1'b1, CMD_ERASE_GO);
    end
    if (prog || op == OP_STATUS) push(1'b1, CMD_STATUS);
    if (op == OP_READ_ID) begin
      push(1'b1, CMD_READ_ID);
      push(1'b0, ID_ADDR);
    end
    if (op == OP_RESET && !ref_rst) push(1'b1, CMD_RESET);
    if (prog) ref_fail = inj;
    if (op == OP_RESET) ref_fail = 1'b0;
    if (!refuse) ref_rst = (op == OP_RESET);
    @(posedge ref_clk);
    req <= '{op: op, src_row: s, dst_row: d};
    fail_inj <= inj;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 3000);
    cmp1(resp_valid, 1'b1, "answer");
    cmp_log();
    if (prog || op == OP_STATUS) begin
      cmp8(resp.status, {2'h3, 5'h00, ref_fail}, "status");
      cmp1(resp.fail, ref_fail, "fail");
    end
    if (op == OP_READ_ID) begin
      cmp8(resp.id_maker, MAKER, "maker");
      cmp8(resp.id_device, DEVICE, "device");
    end
    cmp1(resp.refused, refuse, "refused");
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence: directed cases, random mix, reset in mid-run
  initial begin
    logic [15:0] rs;
    logic [15:0] rd;
    void'($urandom(55));
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (15) @(negedge ref_clk);
    cmp1(wp_n, 1'b0, "protect low");
    cmp1(we_n, 1'b1, "early write");
    run_op(OP_STATUS, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_READ_ID, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_ERASE, 16'hFFFF, 16'h0000, 1'b1);
    run_op(OP_STATUS, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_RESET, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_RESET, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_STATUS, 16'h0000, 16'h0000, 1'b0);
    run_op(OP_COPYBACK, 16'h0020, 16'h0000, 1'b0);
    run_op(OP_COPYBACK, 16'h1234, 16'h5678, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rs = 16'($urandom);
      rd = 16'($urandom);
      rd[PLANE_ROW_BIT] = rs[PLANE_ROW_BIT];
      run_op(nfhc_op_t'($urandom_range(5, 0)), rs, rd, 1'($urandom));
    end
    run_op(OP_STATUS, 16'h0000, 16'h0000, 1'b0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    run_op(OP_STATUS, 16'h0000, 16'h0000, 1'b0);
    tally_and_finish();
  end
  // Watchdog: about 30 requests of under 100 cycles each, with margin
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
